// File: inc/applicator_pkg.sv
// package for the applicator discrete control block
// assumes a single 200 MHz clock and synchronous active-high reset
package applicator_pkg;

    // timing
    localparam int CLK_HZ          = 200_000_000;
    localparam int MIN_PULSE_MS    = 250;
    localparam int MIN_PULSE_CYC   = (CLK_HZ / 1000) * MIN_PULSE_MS;
    localparam int QUAL_W          = 26;

    // job number width: three bcd digits
    localparam int BCD_DIGITS      = 3;
    localparam int JOB_W           = 4 * BCD_DIGITS;
    localparam int JOB_BIN_W       = 10;
    localparam int TOTAL_W         = 32;

    // command input bit positions
    localparam int CMD_TRIG        = 0;
    localparam int CMD_HALT        = 1;
    localparam int CMD_CLEAN       = 2;
    localparam int CMD_RUN         = 3;
    localparam int CMD_MASK        = 4;
    localparam int CMD_TRESET      = 5;
    localparam int CMD_STROBE      = 6;
    localparam int CMD_ENABLE      = 7;
    localparam int CMD_W           = 8;

    // register map (apb byte offsets)
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_HOSTCMD = 12'h004;
    localparam logic [11:0] OFS_FORCE   = 12'h008;
    localparam logic [11:0] OFS_STATUS  = 12'h00c;
    localparam logic [11:0] OFS_JOB     = 12'h010;
    localparam logic [11:0] OFS_DAILY   = 12'h014;
    localparam logic [11:0] OFS_JOBTOT  = 12'h018;
    localparam logic [11:0] OFS_CUMTOT  = 12'h01c;

    // control register fields
    localparam int CTRL_MANUAL     = 0;
    localparam int CTRL_FLOWTRIG   = 1;
    localparam int CTRL_CONFIG_OK  = 2;
    localparam int CTRL_PERMIT     = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0004;

    typedef enum {ST_HALT, ST_RUN, ST_LOAD, ST_CLEAN} mode_type;

    typedef struct packed {
        logic [CMD_W-1:0] level;
        logic             strobe_bcd_ok;
    } cmd_type;

    typedef struct packed {
        logic             flow_on;
        logic             regs_open;
        logic             low_flow_fault;
        logic [JOB_W-1:0] active_job;
        logic [JOB_W-1:0] queued_job;
    } status_type;

endpackage

// File: logic/applicator_ctrl.sv
// discrete control for one applicator: qualified pulses, modes, job queue, totals
// assumes plc inputs synchronous to CLK_I; flow pulses come from the meters
//
// What this block does
// - automatic applicator flows on trigger when running, configured and permitted
// - manual applicator meters in load mode only with trigger active
// - trigger with no catalyst flow while flow is on raises low-flow fault
// - switch one on: master flow replaces trigger input
// - halt stops job or clean and clears faults, except a fault raised in the same cycle; history kept
// - while halted, strobed job enters the queue
// - halt leaves queued job number unchanged
// - clean drives all regulators fully open
// - clean ends on enable removal or halt
// - run pulse activates applicator like panel on switch
// - run pulses after job start are ignored
// - run after halt activates the queued job number
// - queue unchanged without new entry; same job reruns
// - select mask high admits strobed job, low excludes it
// - total reset pulse clears daily and job totals
// - total reset leaves cumulative total alone
// - inputs reachable over host link and forcible from panel
// - on strobe sample job select and mask, load queue
// - job select is three bcd digits of four bits
// - no flow in any mode without enable interlock
`timescale 1ns/1ps
`default_nettype none
module applicator_ctrl #(
    parameter int QUAL_CYCLES = applicator_pkg::MIN_PULSE_CYC
) (
    // clock and reset
    input  wire logic                              CLK_I,
    input  wire logic                              RST_I,
    // plc discrete inputs
    input  wire logic [applicator_pkg::CMD_W-1:0]  CMD_I,
    input  wire logic [applicator_pkg::JOB_W-1:0]  JOB_SEL_I,
    // flow meters, one pulse per unit volume
    input  wire logic                              MASTER_FLOW_I,
    input  wire logic                              CATALYST_FLOW_I,
    // apb slave
    input  wire logic                              PSEL_I,
    input  wire logic                              PENABLE_I,
    input  wire logic                              PWRITE_I,
    input  wire logic [11:0]                       PADDR_I,
    input  wire logic [31:0]                       PWDATA_I,
    output logic      [31:0]                       PRDATA_O,
    output logic                                   PREADY_O,
    output logic                                   PSLVERR_O,
    // applicator outputs
    output logic                                   FLOW_ON_O,
    output logic                                   REGS_OPEN_O,
    output logic                                   LOW_FLOW_FAULT_O,
    output logic      [applicator_pkg::JOB_W-1:0]  ACTIVE_JOB_O
);

    // refuse settings that the qualify counters or the register words cannot hold
    if (QUAL_CYCLES < 1 || QUAL_CYCLES >= (1 << applicator_pkg::QUAL_W)) begin : g_bad_qual
        $error("QUAL_CYCLES out of range");
    end
    if (applicator_pkg::CMD_W != 8 || applicator_pkg::JOB_W > 16) begin : g_bad_width
        $error("command or job width does not fit the register words");
    end

    localparam int CW = applicator_pkg::CMD_W;
    localparam int JW = applicator_pkg::JOB_W;
    localparam int TW = applicator_pkg::TOTAL_W;
    localparam int QW = applicator_pkg::QUAL_W;
    localparam logic [QW-1:0] QUAL_MAX = QW'(QUAL_CYCLES);

    typedef struct packed {
        logic [CW-1:0]         sync1;
        logic [CW-1:0]         sync2;
        logic [CW-1:0][QW-1:0] cnt;
        logic [CW-1:0]         qual;
        logic [31:0]           ctrl;
        logic [CW-1:0]         host_cmd;
        logic [CW-1:0]         force_cmd;
        logic [2:0]            mode;
        logic                  fault;
        logic                  job_started;
        logic [JW-1:0]         queued_job;
        logic [JW-1:0]         active_job;
        logic [TW-1:0]         daily;
        logic [TW-1:0]         job_tot;
        logic [TW-1:0]         cum_tot;
        logic                  flow_on;
        logic                  regs_open;
        logic [31:0]           rdata;
    } state_type;

    state_type s_reg;
    state_type s_next;

    // status word layout; the pad keeps the word exactly 32 bits
    typedef struct packed {
        logic [24-CW:0] pad;
        logic [2:0]     mode;
        logic [CW-1:0]  inputs;
        logic           started;
        logic           fault;
        logic           regs_open;
        logic           flow_on;
    } status_word_type;

    // a job select is valid only if every digit is decimal
    function automatic logic bcd_ok(input logic [JW-1:0] v);
        logic ok;
        ok = 1'b1;
        for (int d = 0; d < applicator_pkg::BCD_DIGITS; d++) begin
            if (v[d*4 +: 4] > 4'h9)
                ok = 1'b0;
        end
        return ok;
    endfunction

    function automatic logic [2:0] mode_code(input applicator_pkg::mode_type m);
        return 3'(m);
    endfunction

    logic [CW-1:0] merged;
    logic [CW-1:0] rise;
    logic          trig_on;
    logic          enable;
    logic          apb_wr;
    logic          apb_rd;
    logic          addr_hit;

    always_comb begin
        merged  = s_reg.sync2 | s_reg.host_cmd | s_reg.force_cmd;
        rise    = '0;
        trig_on = 1'b0;
        enable  = 1'b0;
        apb_wr  = PSEL_I & PENABLE_I & PWRITE_I;
        apb_rd  = PSEL_I & ~PWRITE_I;
        addr_hit = (PADDR_I == applicator_pkg::OFS_CTRL)    ||
                   (PADDR_I == applicator_pkg::OFS_HOSTCMD) ||
                   (PADDR_I == applicator_pkg::OFS_FORCE)   ||
                   (PADDR_I == applicator_pkg::OFS_STATUS)  ||
                   (PADDR_I == applicator_pkg::OFS_JOB)     ||
                   (PADDR_I == applicator_pkg::OFS_DAILY)   ||
                   (PADDR_I == applicator_pkg::OFS_JOBTOT)  ||
                   (PADDR_I == applicator_pkg::OFS_CUMTOT);

        s_next = s_reg;
        s_next.sync1 = CMD_I;
        s_next.sync2 = s_reg.sync1;

        for (int i = 0; i < CW; i++) begin
            if (!merged[i]) begin
                s_next.cnt[i]  = '0;
                s_next.qual[i] = 1'b0;
            end else if (s_reg.cnt[i] < QUAL_MAX) begin
                s_next.cnt[i] = s_reg.cnt[i] + 1'b1;
            end else begin
                s_next.qual[i] = 1'b1;
            end
        end
        // act once on qualified rising edge
        rise = s_next.qual & ~s_reg.qual;

        // enable is a maintained level, interlock acts on the raw merged level
        enable = merged[applicator_pkg::CMD_ENABLE];
        // master flow stands in for trigger
        if (s_reg.ctrl[applicator_pkg::CTRL_FLOWTRIG])
            trig_on = MASTER_FLOW_I;
        else
            trig_on = merged[applicator_pkg::CMD_TRIG];

        if (rise[applicator_pkg::CMD_STROBE] && merged[applicator_pkg::CMD_MASK] &&
            bcd_ok(JOB_SEL_I) && s_reg.mode == mode_code(applicator_pkg::ST_HALT))
            s_next.queued_job = JOB_SEL_I;

        case (s_reg.mode)
            mode_code(applicator_pkg::ST_HALT): begin
                if (rise[applicator_pkg::CMD_RUN] && enable) begin
                    s_next.mode        = mode_code(applicator_pkg::ST_RUN);
                    s_next.active_job  = s_reg.queued_job;
                    s_next.job_started = 1'b1;
                end else if (rise[applicator_pkg::CMD_CLEAN] && enable) begin
                    s_next.mode = mode_code(applicator_pkg::ST_CLEAN);
                end
            end
            mode_code(applicator_pkg::ST_RUN): begin
                // repeated run ignored: no branch acts on it here
                if (rise[applicator_pkg::CMD_CLEAN])
                    s_next.mode = mode_code(applicator_pkg::ST_CLEAN);
                else if (rise[applicator_pkg::CMD_TRIG] &&
                         s_reg.ctrl[applicator_pkg::CTRL_MANUAL])
                    s_next.mode = mode_code(applicator_pkg::ST_LOAD);
            end
            mode_code(applicator_pkg::ST_LOAD): begin
                if (rise[applicator_pkg::CMD_CLEAN])
                    s_next.mode = mode_code(applicator_pkg::ST_CLEAN);
            end
            mode_code(applicator_pkg::ST_CLEAN): begin
                if (!enable)
                    s_next.mode = mode_code(applicator_pkg::ST_HALT);
            end
            default: s_next.mode = mode_code(applicator_pkg::ST_HALT);
        endcase

        // halt stops job or clean, clears fault
        if (rise[applicator_pkg::CMD_HALT]) begin
            s_next.mode        = mode_code(applicator_pkg::ST_HALT);
            s_next.job_started = 1'b0;
            s_next.fault       = 1'b0;
        end

        // trigger without catalyst flow
        // placed after the halt clear so a fault in the clearing cycle wins
        if (trig_on && !CATALYST_FLOW_I && s_reg.flow_on)
            s_next.fault = 1'b1;

        // manual metering only in load with trigger
        s_next.flow_on = 1'b0;
        if (enable && !s_reg.fault && s_reg.ctrl[applicator_pkg::CTRL_PERMIT] &&
            s_reg.ctrl[applicator_pkg::CTRL_CONFIG_OK] && trig_on) begin
            if (s_reg.ctrl[applicator_pkg::CTRL_MANUAL])
                s_next.flow_on = (s_reg.mode == mode_code(applicator_pkg::ST_LOAD));
            else
                s_next.flow_on = (s_reg.mode == mode_code(applicator_pkg::ST_RUN));
        end
        s_next.regs_open = enable && (s_reg.mode == mode_code(applicator_pkg::ST_CLEAN));

        // totals count master meter pulses while material moves
        if (MASTER_FLOW_I && (s_reg.flow_on || s_reg.regs_open)) begin
            s_next.daily   = s_reg.daily + 1'b1;
            s_next.job_tot = s_reg.job_tot + 1'b1;
            s_next.cum_tot = s_reg.cum_tot + 1'b1;
        end
        if (rise[applicator_pkg::CMD_TRESET]) begin
            s_next.daily   = '0;
            s_next.job_tot = '0;
        end

        // host commands without the enable bit are self-clearing pulses held for the qualify window
        if (s_reg.host_cmd != '0 && (s_next.qual & s_reg.host_cmd) == s_reg.host_cmd &&
            s_reg.host_cmd[applicator_pkg::CMD_ENABLE] == 1'b0)
            s_next.host_cmd = '0;

        if (apb_wr) begin
            case (PADDR_I)
                applicator_pkg::OFS_CTRL:    s_next.ctrl      = PWDATA_I;
                applicator_pkg::OFS_HOSTCMD: s_next.host_cmd  = PWDATA_I[CW-1:0];
                applicator_pkg::OFS_FORCE:   s_next.force_cmd = PWDATA_I[CW-1:0];
                default: ;
            endcase
        end

        s_next.rdata = '0;
        if (apb_rd && !PENABLE_I) begin
            case (PADDR_I)
                applicator_pkg::OFS_CTRL:    s_next.rdata = s_reg.ctrl;
                applicator_pkg::OFS_HOSTCMD: s_next.rdata = {24'h0, s_reg.host_cmd};
                applicator_pkg::OFS_FORCE:   s_next.rdata = {24'h0, s_reg.force_cmd};
                applicator_pkg::OFS_STATUS:
                    s_next.rdata = status_word_type'{pad:       '0,
                                                     mode:      s_reg.mode,
                                                     inputs:    merged,
                                                     started:   s_reg.job_started,
                                                     fault:     s_reg.fault,
                                                     regs_open: s_reg.regs_open,
                                                     flow_on:   s_reg.flow_on};
                applicator_pkg::OFS_JOB:
                    s_next.rdata = {4'h0, s_reg.active_job, 4'h0, s_reg.queued_job};
                applicator_pkg::OFS_DAILY:   s_next.rdata = s_reg.daily;
                applicator_pkg::OFS_JOBTOT:  s_next.rdata = s_reg.job_tot;
                applicator_pkg::OFS_CUMTOT:  s_next.rdata = s_reg.cum_tot;
                default:                     s_next.rdata = '0;
            endcase
        end else if (apb_rd) begin
            s_next.rdata = s_reg.rdata;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            s_reg      <= '0;
            s_reg.ctrl <= applicator_pkg::CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // zero wait states: read data is captured in the setup cycle, access completes
    assign PREADY_O         = 1'b1;
    assign PSLVERR_O        = PSEL_I & PENABLE_I & ~addr_hit;
    assign PRDATA_O         = s_reg.rdata;
    assign FLOW_ON_O        = s_reg.flow_on;
    assign REGS_OPEN_O      = s_reg.regs_open;
    assign LOW_FLOW_FAULT_O = s_reg.fault;
    assign ACTIVE_JOB_O     = s_reg.active_job;

endmodule
`default_nettype wire

// File: tb/plc_model.sv
// external plc model: owns the discrete command levels of one applicator
// assumes the bench calls its tasks; changes land just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module plc_model #(
    parameter int HOLD = 8
) (
    input  wire logic                             clk_i,
    output logic      [applicator_pkg::CMD_W-1:0] cmd_o
);
    initial cmd_o = '0;

    // purge steps belong to the plc: this model only sequences command levels
    task automatic level(input int b, input logic v);
        @(posedge clk_i);
        cmd_o[b] <= v;
    endtask

    task automatic pulse(input int b, input int n = HOLD);
        level(b, 1'b1);
        repeat (n) @(posedge clk_i);
        cmd_o[b] <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: tb/applicator_checker_properties.sv
// port assertions for the applicator control block
// assumes host and panel registers never force the enable input
`timescale 1ns/1ps
`default_nettype none
module applicator_checker #(
    parameter int QUAL_CYCLES = 4
) (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic [7:0]  CMD_I,
    input wire logic        CATALYST_FLOW_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        FLOW_ON_O,
    input wire logic        REGS_OPEN_O,
    input wire logic        LOW_FLOW_FAULT_O
);
    localparam int unsigned TOP = QUAL_CYCLES + 5;
    int unsigned halt_cnt;
    int unsigned clean_cnt;
    int unsigned off_cnt;
    logic        bad_addr;

    // saturating so each held pulse hits TOP - 1 once; off_cnt stays at TOP while enable is low
    function automatic int unsigned nxt(input int unsigned c, input logic on);
        return !on ? 0 : (c < TOP ? c + 1 : TOP);
    endfunction

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            halt_cnt  <= 0;
            clean_cnt <= 0;
            off_cnt   <= 0;
        end else begin
            halt_cnt  <= nxt(halt_cnt, CMD_I[applicator_pkg::CMD_HALT]);
            clean_cnt <= nxt(clean_cnt, CMD_I[applicator_pkg::CMD_CLEAN]);
            off_cnt   <= nxt(off_cnt, !CMD_I[applicator_pkg::CMD_ENABLE]);
        end
    end

    assign bad_addr = PADDR_I > 12'h01c || PADDR_I[1:0] != 2'h0;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    chk_ready_zero_wait: assert property (
        PSEL_I && !PENABLE_I |=> PREADY_O) else $error("apb wait state inserted");
    chk_unmapped_err: assert property (
        PSEL_I && PENABLE_I && bad_addr |-> PSLVERR_O) else $error("no error on unmapped");
    chk_mapped_no_err: assert property (
        PSEL_I && PENABLE_I && !bad_addr |-> !PSLVERR_O) else $error("error on mapped");
    chk_fault_cause: assert property (
        $rose(LOW_FLOW_FAULT_O) |-> !$past(CATALYST_FLOW_I)) else $error("fault with flow");
    chk_halt_clears_fault: assert property (
        halt_cnt == TOP - 1 && CATALYST_FLOW_I |-> ##[1:8] !LOW_FLOW_FAULT_O)
        else $error("halt kept fault");
    chk_halt_stops_all: assert property (
        halt_cnt == TOP - 1 |-> ##[1:8] !(FLOW_ON_O || REGS_OPEN_O))
        else $error("halt kept flow or clean");
    chk_clean_opens: assert property (
        clean_cnt == TOP - 1 && CMD_I[applicator_pkg::CMD_ENABLE]
        && !CMD_I[applicator_pkg::CMD_HALT] |-> ##[1:8] REGS_OPEN_O)
        else $error("clean did not open regulators");
    chk_enable_off_stops: assert property (
        off_cnt == TOP |-> ##[0:8] !(FLOW_ON_O || REGS_OPEN_O))
        else $error("flow without enable");

    cover property ($rose(FLOW_ON_O));
    cover property ($rose(REGS_OPEN_O));
    cover property ($rose(LOW_FLOW_FAULT_O));
endmodule

bind applicator_ctrl applicator_checker #(.QUAL_CYCLES(QUAL_CYCLES)) chk (
    .CLK_I(CLK_I), .RST_I(RST_I), .CMD_I(CMD_I), .CATALYST_FLOW_I(CATALYST_FLOW_I),
    .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .FLOW_ON_O(FLOW_ON_O), .REGS_OPEN_O(REGS_OPEN_O),
    .LOW_FLOW_FAULT_O(LOW_FLOW_FAULT_O));
`default_nettype wire

// File: tb/applicator_discrete_control_tb.sv
// self-checking bench for the applicator control block
// assumes plc_model drives the commands; apb and meters are driven here
`timescale 1ns/1ps
`default_nettype none
module applicator_discrete_control_tb;
    localparam int Q = 4;
    localparam int TRIG = applicator_pkg::CMD_TRIG, HALT = applicator_pkg::CMD_HALT;
    localparam int CLEAN = applicator_pkg::CMD_CLEAN, RUN = applicator_pkg::CMD_RUN;
    localparam int MASK = applicator_pkg::CMD_MASK, TRES = applicator_pkg::CMD_TRESET;
    localparam int STRB = applicator_pkg::CMD_STROBE, EN = applicator_pkg::CMD_ENABLE;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  cmd;
    logic [11:0] job_sel = 12'h000;
    logic        master = 1'b0;
    logic        cat = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, cum;
    logic        pready, pslverr, flow, regs, fault, err;
    logic [11:0] act;
    int          fails = 0;
    int          checks = 0;

    always #2.5 clk = ~clk;

    plc_model #(.HOLD(Q + 4)) plc (.clk_i(clk), .cmd_o(cmd));

    applicator_ctrl #(.QUAL_CYCLES(Q)) uut (
        .CLK_I(clk), .RST_I(rst), .CMD_I(cmd), .JOB_SEL_I(job_sel),
        .MASTER_FLOW_I(master), .CATALYST_FLOW_I(cat), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .FLOW_ON_O(flow), .REGS_OPEN_O(regs),
        .LOW_FLOW_FAULT_O(fault), .ACTIVE_JOB_O(act));

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0);
        int n;
        n = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        if (n >= 20) fails++;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    // pulse one command, then allow qualification and the registered effect
    task automatic go(input int b);
        plc.pulse(b);
        repeat (Q + 8) @(posedge clk);
    endtask

    task automatic t_regs;
        apb(1'b0, applicator_pkg::OFS_CTRL);
        check("ctrl reset", rd, applicator_pkg::CTRL_RESET);
        apb(1'b1, applicator_pkg::OFS_CTRL, 32'hc);
        apb(1'b0, applicator_pkg::OFS_CTRL);
        check("ctrl rw", rd, 32'hc);
        apb(1'b0, 12'h020);
        check("unmapped err", 32'(err), 32'h1);
        check("unmapped data", rd, 32'h0);
    endtask

    task automatic t_run;
        plc.level(EN, 1'b1);
        plc.level(MASK, 1'b1);
        job_sel <= 12'h123;
        go(STRB);
        apb(1'b0, applicator_pkg::OFS_JOB);
        check("queued", 32'(rd[11:0]), 32'h123);
        plc.level(TRIG, 1'b1);
        master <= 1'b1;
        cat    <= 1'b1;
        go(RUN);
        check("flow on", 32'(flow), 32'h1);
        check("active", 32'(act), 32'h123);
        job_sel <= 12'h456;
        go(STRB);
        go(RUN);
        check("rerun ignored", 32'(act), 32'h123);
        apb(1'b0, applicator_pkg::OFS_JOB);
        check("strobe in run", 32'(rd[11:0]), 32'h123);
    endtask

    task automatic t_fault;
        cat <= 1'b0;
        repeat (Q + 8) @(posedge clk);
        check("low flow", 32'(fault), 32'h1);
        cat <= 1'b1;
        go(HALT);
        check("fault cleared", 32'(fault), 32'h0);
        check("halt flow", 32'(flow), 32'h0);
        apb(1'b0, applicator_pkg::OFS_JOB);
        check("halt queue", 32'(rd[11:0]), 32'h123);
    endtask

    task automatic t_queue;
        plc.level(MASK, 1'b0);
        go(STRB);
        apb(1'b0, applicator_pkg::OFS_JOB);
        check("masked", 32'(rd[11:0]), 32'h123);
        plc.level(MASK, 1'b1);
        job_sel <= 12'h1a3;
        go(STRB);
        apb(1'b0, applicator_pkg::OFS_JOB);
        check("non bcd", 32'(rd[11:0]), 32'h123);
        plc.pulse(RUN, Q - 1);
        repeat (Q + 8) @(posedge clk);
        check("short run", 32'(flow), 32'h0);
        go(RUN);
        check("same job", 32'(act), 32'h123);
        check("flow again", 32'(flow), 32'h1);
    endtask

    task automatic t_totals;
        go(HALT);
        apb(1'b0, applicator_pkg::OFS_CUMTOT);
        cum = rd;
        apb(1'b0, applicator_pkg::OFS_DAILY);
        check("daily counted", 32'(rd != 0), 32'h1);
        go(TRES);
        apb(1'b0, applicator_pkg::OFS_DAILY);
        check("daily reset", rd, 32'h0);
        apb(1'b0, applicator_pkg::OFS_JOBTOT);
        check("job reset", rd, 32'h0);
        apb(1'b0, applicator_pkg::OFS_CUMTOT);
        check("cumulative", rd, cum);
    endtask

    task automatic t_clean;
        go(CLEAN);
        check("clean open", 32'(regs), 32'h1);
        go(HALT);
        check("halt ends", 32'(regs), 32'h0);
        go(CLEAN);
        plc.level(EN, 1'b0);
        repeat (Q + 8) @(posedge clk);
        check("enable ends", 32'(regs), 32'h0);
        check("no flow", 32'(flow), 32'h0);
        plc.level(EN, 1'b1);
        go(HALT);
        apb(1'b1, applicator_pkg::OFS_CTRL, 32'he);
        plc.level(TRIG, 1'b0);
        go(RUN);
        check("flow trigger", 32'(flow), 32'h1);
    endtask

    task automatic t_load;
        go(HALT);
        apb(1'b1, applicator_pkg::OFS_CTRL, 32'hd);
        go(RUN);
        check("manual run", 32'(flow), 32'h0);
        plc.level(TRIG, 1'b1);
        repeat (Q + 8) @(posedge clk);
        check("load flow", 32'(flow), 32'h1);
        apb(1'b0, applicator_pkg::OFS_STATUS);
        check("load mode", 32'(rd[14:12]), 32'h2);
        plc.level(TRIG, 1'b0);
        repeat (Q + 8) @(posedge clk);
        check("load no trig", 32'(flow), 32'h0);
    endtask

    task automatic final_report;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_run;
        t_fault;
        t_queue;
        t_totals;
        t_clean;
        t_load;
        final_report;
    end

    // whole run is well under this span
    initial begin
        repeat (4000) @(posedge clk);
        fails++;
        final_report;
    end
endmodule
`default_nettype wire
